// File: include/conv_ctrl_pkg.sv
/*
 * Constants, register map and carrier types for the converter front-end
 * control block. Assumes a plain one-cycle register port and one 125 MHz clock.
 */
// Behaviour
// - primary range field picks eight doubling spans
// - auxiliary converter has fixed span, no gain
// - unipolar bit changes coding only, not conditioning
// - unipolar results are straight binary
// - bipolar results are offset binary
// - one burnout bit drives both test currents
// - excitation bits route sources separately or combined
// - external reference bit zero selects internal bandgap
// - no-reference flag set on low or open reference
// - no reference forces conversion results to all ones
// - no reference blocks calibration write, sets error
package conv_ctrl_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int REG_W = 8;
    // register offsets
    localparam logic [ADDR_W-1:0] PRIMARY_CONV_CONTROL_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] AUX_CONV_CONTROL_OFS = 4'h1;
    localparam logic [ADDR_W-1:0] CURRENT_SOURCE_CONTROL_OFS = 4'h2;
    localparam logic [ADDR_W-1:0] CONVERTER_STATUS_OFS = 4'h3;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 4'h5;
    localparam logic [ADDR_W-1:0] PRIMARY_DATA_LO_OFS = 4'h6;
    localparam logic [ADDR_W-1:0] PRIMARY_DATA_HI_OFS = 4'h7;
    localparam logic [ADDR_W-1:0] AUX_DATA_LO_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] AUX_DATA_HI_OFS = 4'h9;
    // control field positions
    localparam int RANGE_LSB = 0;
    localparam int RANGE_W = 3;
    localparam int UNIPOLAR_BIT = 5;
    localparam int EXT_REF_BIT = 6;
    localparam int BURNOUT_BIT = 0;
    localparam int EXC_A_BIT = 1;
    localparam int EXC_B_BIT = 2;
    localparam int EXC_PIN_B_BIT = 3;
    localparam int EXC_COMBINE_BIT = 4;
    // status field positions
    localparam int PRI_READY_BIT = 0;
    localparam int AUX_READY_BIT = 1;
    localparam int PRI_ERR_BIT = 2;
    localparam int AUX_ERR_BIT = 3;
    localparam int NOREF_BIT = 4;
    // reset values
    localparam logic [REG_W-1:0] PRIMARY_CTRL_RST = 8'h07;
    localparam logic [REG_W-1:0] AUX_CTRL_RST = 8'h00;
    localparam logic [REG_W-1:0] CURRENT_CTRL_RST = 8'h00;
    localparam logic [REG_W-1:0] IRQ_MASK_RST = 8'h00;
    localparam logic [DATA_W-1:0] ALL_ONES = 16'hFFFF;
    localparam logic [DATA_W-1:0] MIDSCALE = 16'h8000;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN = 2'b01,
        CAL_DONE = 2'b11
    } cal_state_e;

    // per-converter settings latched at conversion start
    typedef struct packed {
        logic [RANGE_W-1:0] range;
        logic unipolar;
        logic ext_ref;
    } conv_cfg_s;

    // analog switch controls toward the current sources
    typedef struct packed {
        logic burnout_source;
        logic burnout_sink;
        logic exc1_to_a;
        logic exc1_to_b;
        logic exc2_to_a;
        logic exc2_to_b;
    } isrc_sw_s;
endpackage : conv_ctrl_pkg

// File: design/conv_result_path.sv
/*
 * Result path of one converter: output coding, all-ones substitution on
 * reference loss and gating of calibration coefficient writes. Assumes the
 * filter hands over a signed two's complement word with a one-cycle valid.
 */
`timescale 1ns/1ps
`default_nettype none
module conv_result_path
    import conv_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // filter side
    input wire logic done_i,
    input wire logic [DATA_W-1:0] raw_i,
    input wire logic is_cal_i,
    input wire logic unipolar_i,
    input wire logic noref_i,
    // results
    output logic [DATA_W-1:0] data_o,
    output logic data_wr_o,
    output logic cal_wr_o,
    output logic cal_err_o
);
    logic [DATA_W-1:0] data_r, data_nxt;
    logic data_wr_r, data_wr_nxt, cal_wr_r, cal_wr_nxt, cal_err_r, cal_err_nxt;
    logic [DATA_W-1:0] coded;

    always_comb begin
        // unipolar passes magnitude straight; bipolar flips the top bit
        coded = unipolar_i ? raw_i : (raw_i ^ MIDSCALE);
        data_nxt = data_r;
        data_wr_nxt = 1'b0;
        cal_wr_nxt = 1'b0;
        cal_err_nxt = 1'b0;
        if (done_i && !is_cal_i) begin
            data_wr_nxt = 1'b1;
            data_nxt = noref_i ? ALL_ONES : coded;
        end else if (done_i && is_cal_i) begin
            cal_wr_nxt = !noref_i;
            cal_err_nxt = noref_i;
            data_nxt = noref_i ? data_r : coded;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            data_r <= '0;
            data_wr_r <= 1'b0;
            cal_wr_r <= 1'b0;
            cal_err_r <= 1'b0;
        end else begin
            data_r <= data_nxt;
            data_wr_r <= data_wr_nxt;
            cal_wr_r <= cal_wr_nxt;
            cal_err_r <= cal_err_nxt;
        end
    end

    assign data_o = data_r;
    assign data_wr_o = data_wr_r;
    assign cal_wr_o = cal_wr_r;
    assign cal_err_o = cal_err_r;

    noref_ones_a: assert property (@(posedge clk_i) disable iff (srst_i)
        done_i && !is_cal_i && noref_i |=> data_wr_o && data_o == ALL_ONES)
        else $error("result not forced to all ones without reference");
    cal_block_a: assert property (@(posedge clk_i) disable iff (srst_i)
        done_i && is_cal_i && noref_i |=> !cal_wr_o && cal_err_o)
        else $error("calibration write not blocked without reference");
    bipolar_code_a: assert property (@(posedge clk_i) disable iff (srst_i)
        done_i && !is_cal_i && !noref_i && !unipolar_i && raw_i == '0
        |=> data_o == MIDSCALE)
        else $error("bipolar zero input not coded as midscale");
endmodule : conv_result_path
`default_nettype wire

// File: design/adc_front_end_ref_detect_ctrl.sv
/*
 * Control and status registers of a dual sigma-delta front end: range,
 * coding, reference select, current sources, reference detect, calibration
 * error and interrupt. Assumes one 125 MHz clock, a plain register port,
 * and asynchronous detector and converter strobes from the analog side
 * (converter done strobes are level-toggle events, start inputs are pulses, detector inputs are levels).
 */
`timescale 1ns/1ps
`default_nettype none
module adc_front_end_ref_detect_ctrl
    import conv_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [REG_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [REG_W-1:0] rdata_o,
    // reference detector (asynchronous levels)
    input wire logic ref_low_i,
    input wire logic ref_in_pos_open_i,
    input wire logic ref_in_neg_open_i,
    // converter events from the filter (done inputs toggle per conversion, start inputs pulse)
    input wire logic pri_done_tgl_i,
    input wire logic aux_done_tgl_i,
    input wire logic [DATA_W-1:0] pri_raw_i,
    input wire logic [DATA_W-1:0] aux_raw_i,
    input wire logic pri_is_cal_i,
    input wire logic aux_is_cal_i,
    input wire logic pri_start_i,
    input wire logic aux_start_i,
    // analog controls
    output conv_cfg_s pri_cfg_o,
    output conv_cfg_s aux_cfg_o,
    output isrc_sw_s isrc_o,
    output logic pri_cal_wr_o,
    output logic aux_cal_wr_o,
    // interrupt
    output logic irq_o
);
    // synchronisers: stage 1 feeds only stage 2
    logic [4:0] async_in, sync1_r, sync2_r;
    assign async_in = {aux_done_tgl_i, pri_done_tgl_i, ref_in_neg_open_i,
                       ref_in_pos_open_i, ref_low_i};
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= async_in;
            sync2_r <= sync1_r;
        end
    end

    logic noref_now;
    assign noref_now = sync2_r[0] | sync2_r[1] | sync2_r[2];

    logic pri_tgl_d_r, aux_tgl_d_r;
    logic pri_done, aux_done;
    assign pri_done = sync2_r[3] ^ pri_tgl_d_r;
    assign aux_done = sync2_r[4] ^ aux_tgl_d_r;

    // control registers
    logic [REG_W-1:0] pri_ctrl_r, pri_ctrl_nxt;
    logic [REG_W-1:0] aux_ctrl_r, aux_ctrl_nxt;
    logic [REG_W-1:0] cur_ctrl_r, cur_ctrl_nxt;
    logic [REG_W-1:0] mask_r, mask_nxt;
    logic [REG_W-1:0] irq_stat_r, irq_stat_nxt;
    logic pri_err_r, pri_err_nxt, aux_err_r, aux_err_nxt;
    logic pri_rdy_r, pri_rdy_nxt, aux_rdy_r, aux_rdy_nxt;
    logic noref_r;
    conv_cfg_s pri_cfg_r, pri_cfg_nxt, aux_cfg_r, aux_cfg_nxt;
    isrc_sw_s isrc_r, isrc_nxt;
    logic [REG_W-1:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;

    logic [DATA_W-1:0] pri_data, aux_data;
    logic pri_wr, aux_wr, pri_cerr, aux_cerr;
    logic [REG_W-1:0] status_view, ev;
    logic wr_ctrl;

    conv_result_path u_pri (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .done_i(pri_done),
        .raw_i(pri_raw_i),
        .is_cal_i(pri_is_cal_i),
        .unipolar_i(pri_cfg_r.unipolar),
        .noref_i(noref_r),
        .data_o(pri_data),
        .data_wr_o(pri_wr),
        .cal_wr_o(pri_cal_wr_o),
        .cal_err_o(pri_cerr)
    );
    conv_result_path u_aux (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .done_i(aux_done),
        .raw_i(aux_raw_i),
        .is_cal_i(aux_is_cal_i),
        .unipolar_i(aux_cfg_r.unipolar),
        .noref_i(noref_r),
        .data_o(aux_data),
        .data_wr_o(aux_wr),
        .cal_wr_o(aux_cal_wr_o),
        .cal_err_o(aux_cerr)
    );

    always_comb begin
        status_view = '0;
        status_view[PRI_READY_BIT] = pri_rdy_r;
        status_view[AUX_READY_BIT] = aux_rdy_r;
        status_view[PRI_ERR_BIT] = pri_err_r;
        status_view[AUX_ERR_BIT] = aux_err_r;
        status_view[NOREF_BIT] = noref_r;
        ev = '0;
        ev[PRI_READY_BIT] = pri_wr | pri_cal_wr_o | pri_cerr;
        ev[AUX_READY_BIT] = aux_wr | aux_cal_wr_o | aux_cerr;
        ev[PRI_ERR_BIT] = pri_cerr;
        ev[AUX_ERR_BIT] = aux_cerr;
        ev[NOREF_BIT] = noref_now & ~noref_r;
        wr_ctrl = wr_i;
    end

    // register writes and sticky status
    always_comb begin
        pri_ctrl_nxt = pri_ctrl_r;
        aux_ctrl_nxt = aux_ctrl_r;
        cur_ctrl_nxt = cur_ctrl_r;
        mask_nxt = mask_r;
        irq_stat_nxt = irq_stat_r;
        pri_err_nxt = pri_err_r;
        aux_err_nxt = aux_err_r;
        pri_rdy_nxt = pri_rdy_r;
        aux_rdy_nxt = aux_rdy_r;
        if (wr_ctrl) begin
            if (addr_i == PRIMARY_CONV_CONTROL_OFS) begin
                pri_ctrl_nxt = wdata_i;
            end else if (addr_i == AUX_CONV_CONTROL_OFS) begin
                aux_ctrl_nxt = wdata_i;
            end else if (addr_i == CURRENT_SOURCE_CONTROL_OFS) begin
                cur_ctrl_nxt = wdata_i;
            end else if (addr_i == CONVERTER_STATUS_OFS) begin
                // write one clears error and ready flags
                pri_err_nxt = pri_err_r & ~wdata_i[PRI_ERR_BIT];
                aux_err_nxt = aux_err_r & ~wdata_i[AUX_ERR_BIT];
                pri_rdy_nxt = pri_rdy_r & ~wdata_i[PRI_READY_BIT];
                aux_rdy_nxt = aux_rdy_r & ~wdata_i[AUX_READY_BIT];
            end else if (addr_i == IRQ_STATUS_OFS) begin
                irq_stat_nxt = irq_stat_r & ~wdata_i;
            end else if (addr_i == IRQ_MASK_OFS) begin
                mask_nxt = wdata_i;
            end
        end
        // hardware set wins over software clear
        if (pri_cerr) begin
            pri_err_nxt = 1'b1;
        end
        if (aux_cerr) begin
            aux_err_nxt = 1'b1;
        end
        if (ev[PRI_READY_BIT]) begin
            pri_rdy_nxt = 1'b1;
        end
        if (ev[AUX_READY_BIT]) begin
            aux_rdy_nxt = 1'b1;
        end
        irq_stat_nxt = irq_stat_nxt | ev;
    end

    // converter settings take effect at the next conversion start; current sources and irq update every cycle
    always_comb begin
        pri_cfg_nxt = pri_cfg_r;
        aux_cfg_nxt = aux_cfg_r;
        if (pri_start_i) begin
            pri_cfg_nxt.range = pri_ctrl_r[RANGE_LSB +: RANGE_W];
            pri_cfg_nxt.unipolar = pri_ctrl_r[UNIPOLAR_BIT];
            pri_cfg_nxt.ext_ref = pri_ctrl_r[EXT_REF_BIT];
        end
        if (aux_start_i) begin
            aux_cfg_nxt.range = '0;
            aux_cfg_nxt.unipolar = aux_ctrl_r[UNIPOLAR_BIT];
            aux_cfg_nxt.ext_ref = aux_ctrl_r[EXT_REF_BIT];
        end
        isrc_nxt.burnout_source = cur_ctrl_r[BURNOUT_BIT];
        isrc_nxt.burnout_sink = cur_ctrl_r[BURNOUT_BIT];
        // combine steers both sources onto the pin named by the pin select
        if (cur_ctrl_r[EXC_COMBINE_BIT]) begin
            isrc_nxt.exc1_to_a = cur_ctrl_r[EXC_A_BIT] & ~cur_ctrl_r[EXC_PIN_B_BIT];
            isrc_nxt.exc1_to_b = cur_ctrl_r[EXC_A_BIT] & cur_ctrl_r[EXC_PIN_B_BIT];
            isrc_nxt.exc2_to_a = cur_ctrl_r[EXC_B_BIT] & ~cur_ctrl_r[EXC_PIN_B_BIT];
            isrc_nxt.exc2_to_b = cur_ctrl_r[EXC_B_BIT] & cur_ctrl_r[EXC_PIN_B_BIT];
        end else begin
            isrc_nxt.exc1_to_a = cur_ctrl_r[EXC_A_BIT];
            isrc_nxt.exc1_to_b = 1'b0;
            isrc_nxt.exc2_to_a = 1'b0;
            isrc_nxt.exc2_to_b = cur_ctrl_r[EXC_B_BIT];
        end
        irq_nxt = |(irq_stat_nxt & mask_nxt);
    end

    // read data one cycle after the strobe
    always_comb begin
        rdata_nxt = '0;
        if (rd_i) begin
            if (addr_i == PRIMARY_CONV_CONTROL_OFS) begin
                rdata_nxt = pri_ctrl_r;
            end else if (addr_i == AUX_CONV_CONTROL_OFS) begin
                rdata_nxt = aux_ctrl_r;
            end else if (addr_i == CURRENT_SOURCE_CONTROL_OFS) begin
                rdata_nxt = cur_ctrl_r;
            end else if (addr_i == CONVERTER_STATUS_OFS) begin
                rdata_nxt = status_view;
            end else if (addr_i == IRQ_STATUS_OFS) begin
                rdata_nxt = irq_stat_r;
            end else if (addr_i == IRQ_MASK_OFS) begin
                rdata_nxt = mask_r;
            end else if (addr_i == PRIMARY_DATA_LO_OFS) begin
                rdata_nxt = pri_data[7:0];
            end else if (addr_i == PRIMARY_DATA_HI_OFS) begin
                rdata_nxt = pri_data[15:8];
            end else if (addr_i == AUX_DATA_LO_OFS) begin
                rdata_nxt = aux_data[7:0];
            end else if (addr_i == AUX_DATA_HI_OFS) begin
                rdata_nxt = aux_data[15:8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pri_ctrl_r <= PRIMARY_CTRL_RST;
            aux_ctrl_r <= AUX_CTRL_RST;
            cur_ctrl_r <= CURRENT_CTRL_RST;
            mask_r <= IRQ_MASK_RST;
            irq_stat_r <= '0;
            pri_err_r <= 1'b0;
            aux_err_r <= 1'b0;
            pri_rdy_r <= 1'b0;
            aux_rdy_r <= 1'b0;
            noref_r <= 1'b0;
            pri_tgl_d_r <= 1'b0;
            aux_tgl_d_r <= 1'b0;
            pri_cfg_r <= '0;
            aux_cfg_r <= '0;
            isrc_r <= '0;
            rdata_r <= '0;
            irq_r <= 1'b0;
        end else begin
            pri_ctrl_r <= pri_ctrl_nxt;
            aux_ctrl_r <= aux_ctrl_nxt;
            cur_ctrl_r <= cur_ctrl_nxt;
            mask_r <= mask_nxt;
            irq_stat_r <= irq_stat_nxt;
            pri_err_r <= pri_err_nxt;
            aux_err_r <= aux_err_nxt;
            pri_rdy_r <= pri_rdy_nxt;
            aux_rdy_r <= aux_rdy_nxt;
            noref_r <= noref_now;
            pri_tgl_d_r <= sync2_r[3];
            aux_tgl_d_r <= sync2_r[4];
            pri_cfg_r <= pri_cfg_nxt;
            aux_cfg_r <= aux_cfg_nxt;
            isrc_r <= isrc_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign pri_cfg_o = pri_cfg_r;
    assign aux_cfg_o = aux_cfg_r;
    assign isrc_o = isrc_r;
    assign rdata_o = rdata_r;
    assign irq_o = irq_r;

    noref_follow_a: assert property (@(posedge clk_i) disable iff (srst_i)
        ##1 noref_r == $past(noref_now))
        else $error("no-reference flag does not track detector");
    err_sticky_a: assert property (@(posedge clk_i) disable iff (srst_i)
        pri_err_r && !(wr_i && addr_i == CONVERTER_STATUS_OFS) |=> pri_err_r)
        else $error("primary error dropped without a clear");
    burnout_pair_a: assert property (@(posedge clk_i) disable iff (srst_i)
        isrc_o.burnout_source == isrc_o.burnout_sink)
        else $error("burnout currents not switched together");
    aux_range_a: assert property (@(posedge clk_i) disable iff (srst_i)
        aux_cfg_o.range == '0)
        else $error("auxiliary converter shows a gain range");
    cfg_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !pri_start_i |=> $stable(pri_cfg_o))
        else $error("primary settings changed outside a conversion start");
    range_take_a: assert property (@(posedge clk_i) disable iff (srst_i)
        pri_start_i |=> pri_cfg_o.range == $past(pri_ctrl_r[RANGE_LSB +: RANGE_W]))
        else $error("range not taken at conversion start");
    ref_sel_a: assert property (@(posedge clk_i) disable iff (srst_i)
        pri_start_i |=> pri_cfg_o.ext_ref == $past(pri_ctrl_r[EXT_REF_BIT]))
        else $error("reference select not taken at conversion start");
    exc_split_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !cur_ctrl_r[EXC_COMBINE_BIT] |=> !isrc_o.exc1_to_b && !isrc_o.exc2_to_a)
        else $error("excitation sources combined while split selected");
endmodule : adc_front_end_ref_detect_ctrl
`default_nettype wire

// File: test/adc_front_end_ref_detect_ctrl_bench.sv
/*
 * Self-checking bench for the converter front-end control block.
 * Assumes the register map and coding of conv_ctrl_pkg; drives all ports itself.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_front_end_ref_detect_ctrl_bench;
    import conv_ctrl_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [REG_W-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [REG_W-1:0] rdata_o;
    logic ref_low_i = 1'b0;
    logic ref_in_pos_open_i = 1'b0;
    logic ref_in_neg_open_i = 1'b0;
    logic pri_done_tgl_i = 1'b0;
    logic aux_done_tgl_i = 1'b0;
    logic [DATA_W-1:0] pri_raw_i = '0;
    logic [DATA_W-1:0] aux_raw_i = '0;
    logic pri_is_cal_i = 1'b0;
    logic aux_is_cal_i = 1'b0;
    logic pri_start_i = 1'b0;
    logic aux_start_i = 1'b0;
    conv_cfg_s pri_cfg_o;
    conv_cfg_s aux_cfg_o;
    isrc_sw_s isrc_o;
    logic pri_cal_wr_o;
    logic aux_cal_wr_o;
    logic irq_o;
    int errors = 0;
    int checked = 0;
    int cal_pulses = 0;
    int cal_base = 0;
    logic [15:0] cfg_exp = '0;
    logic [7:0] v;
    logic [7:0] hi;
    logic [15:0] tbl [0:9];

    adc_front_end_ref_detect_ctrl uut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ref_low_i(ref_low_i),
        .ref_in_pos_open_i(ref_in_pos_open_i), .ref_in_neg_open_i(ref_in_neg_open_i),
        .pri_done_tgl_i(pri_done_tgl_i), .aux_done_tgl_i(aux_done_tgl_i),
        .pri_raw_i(pri_raw_i), .aux_raw_i(aux_raw_i), .pri_is_cal_i(pri_is_cal_i),
        .aux_is_cal_i(aux_is_cal_i), .pri_start_i(pri_start_i), .aux_start_i(aux_start_i),
        .pri_cfg_o(pri_cfg_o), .aux_cfg_o(aux_cfg_o), .isrc_o(isrc_o),
        .pri_cal_wr_o(pri_cal_wr_o), .aux_cal_wr_o(aux_cal_wr_o), .irq_o(irq_o));

    always #4 clk_i = ~clk_i;

    // counts calibration write permissions of either converter
    always @(posedge clk_i) begin
        if (pri_cal_wr_o === 1'b1 || aux_cal_wr_o === 1'b1) begin
            cal_pulses++;
        end
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd

    task automatic rdchk(input string name, input logic [ADDR_W-1:0] a, input logic [7:0] e);
        rd(a, v);
        chk(name, {8'h00, e}, {8'h00, v});
    endtask : rdchk

    // one conversion or calibration: start pulse, raw word, then the done toggle
    task automatic conv(input bit aux, input logic [15:0] raw, input bit cal);
        @(posedge clk_i);
        if (aux) begin
            aux_start_i <= 1'b1;
            aux_raw_i <= raw;
            aux_is_cal_i <= cal;
        end else begin
            pri_start_i <= 1'b1;
            pri_raw_i <= raw;
            pri_is_cal_i <= cal;
        end
        @(posedge clk_i);
        pri_start_i <= 1'b0;
        aux_start_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        if (aux) begin
            aux_done_tgl_i <= ~aux_done_tgl_i;
        end else begin
            pri_done_tgl_i <= ~pri_done_tgl_i;
        end
        repeat (10) @(posedge clk_i);
    endtask : conv

    task automatic rd16(input bit aux, input logic [15:0] e);
        rd(aux ? AUX_DATA_LO_OFS : PRIMARY_DATA_LO_OFS, v);
        rd(aux ? AUX_DATA_HI_OFS : PRIMARY_DATA_HI_OFS, hi);
        chk(aux ? "aux_data" : "pri_data", e, {hi, v});
    endtask : rd16

    task automatic results;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        #400000;
        errors++;
        results();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        rdchk("pri_ctrl_rst", PRIMARY_CONV_CONTROL_OFS, PRIMARY_CTRL_RST);
        rdchk("aux_ctrl_rst", AUX_CONV_CONTROL_OFS, AUX_CTRL_RST);
        rdchk("isrc_ctrl_rst", CURRENT_SOURCE_CONTROL_OFS, CURRENT_CTRL_RST);
        rdchk("status_rst", CONVERTER_STATUS_OFS, 8'h00);
        rdchk("mask_rst", IRQ_MASK_OFS, IRQ_MASK_RST);
        wr(4'hF, 8'hFF);
        rdchk("unmapped", 4'hF, 8'h00);
        // every range code with mixed polarity and reference choice
        for (int r = 0; r < 8; r++) begin
            wr(PRIMARY_CONV_CONTROL_OFS, 8'(r | ((r & 1) << 5) | ((r & 2) << 5)));
            chk("pri_cfg_hold", cfg_exp, {11'h000, pri_cfg_o});
            conv(1'b0, 16'h0000, 1'b0);
            cfg_exp = 16'(r * 4 + (r & 1) * 2 + ((r >> 1) & 1));
            chk("pri_cfg", cfg_exp, {11'h000, pri_cfg_o});
        end
        wr(AUX_CONV_CONTROL_OFS, 8'h67);
        conv(1'b1, 16'h0000, 1'b0);
        chk("aux_cfg", 16'h0003, {11'h000, aux_cfg_o});
        wr(CURRENT_SOURCE_CONTROL_OFS, 8'h01);
        repeat (2) @(posedge clk_i);
        chk("burnout_on", 16'h0030, {10'h000, isrc_o});
        wr(CURRENT_SOURCE_CONTROL_OFS, 8'h00);
        repeat (2) @(posedge clk_i);
        chk("burnout_off", 16'h0000, {10'h000, isrc_o});
        tbl[0] = 16'h0006;
        tbl[1] = 16'h0009;
        tbl[2] = 16'h0016;
        tbl[3] = 16'h000A;
        tbl[4] = 16'h001E;
        tbl[5] = 16'h0005;
        for (int i = 0; i < 3; i++) begin
            wr(CURRENT_SOURCE_CONTROL_OFS, tbl[2*i][7:0]);
            repeat (2) @(posedge clk_i);
            chk("excitation", tbl[2*i+1], {10'h000, isrc_o});
        end
        // coding table: raw word, expected data register
        tbl[0] = 16'h8000;
        tbl[1] = 16'h8000;
        tbl[2] = 16'hFFFF;
        tbl[3] = 16'hFFFF;
        tbl[4] = 16'h0000;
        tbl[5] = 16'h0000;
        for (int i = 0; i < 3; i++) begin
            wr(PRIMARY_CONV_CONTROL_OFS, 8'h20);
            conv(1'b0, tbl[2*i], 1'b0);
            rd16(1'b0, tbl[2*i+1]);
        end
        tbl[0] = 16'h8000;
        tbl[1] = 16'h0000;
        tbl[2] = 16'h0000;
        tbl[3] = 16'h8000;
        tbl[4] = 16'h7FFF;
        tbl[5] = 16'hFFFF;
        for (int i = 0; i < 3; i++) begin
            wr(PRIMARY_CONV_CONTROL_OFS, 8'h43);
            conv(1'b0, tbl[2*i], 1'b0);
            rd16(1'b0, tbl[2*i+1]);
        end
        wr(AUX_CONV_CONTROL_OFS, 8'h20);
        conv(1'b1, 16'h1234, 1'b0);
        rd16(1'b1, 16'h1234);
        wr(AUX_CONV_CONTROL_OFS, 8'h00);
        conv(1'b1, 16'h1234, 1'b0);
        rd16(1'b1, 16'h9234);
        // interrupt: unmasked ready raises the line, clear drops it, masked stays quiet
        wr(CONVERTER_STATUS_OFS, 8'h0F);
        wr(IRQ_STATUS_OFS, 8'h1F);
        wr(IRQ_MASK_OFS, 8'h01);
        conv(1'b0, 16'h0001, 1'b0);
        chk("irq_set", 16'h0001, {15'h0000, irq_o});
        rdchk("irq_status", IRQ_STATUS_OFS, 8'h01);
        wr(IRQ_STATUS_OFS, 8'h01);
        repeat (2) @(posedge clk_i);
        chk("irq_clr", 16'h0000, {15'h0000, irq_o});
        wr(IRQ_MASK_OFS, 8'h00);
        conv(1'b0, 16'h0001, 1'b0);
        chk("irq_masked", 16'h0000, {15'h0000, irq_o});
        // calibration with a good reference is allowed to write
        wr(CONVERTER_STATUS_OFS, 8'h0F);
        cal_base = cal_pulses;
        conv(1'b0, 16'h0100, 1'b1);
        conv(1'b1, 16'h0100, 1'b1);
        chk("cal_wr_ok", 16'h0002, 16'(cal_pulses - cal_base));
        rdchk("cal_ready", CONVERTER_STATUS_OFS, 8'h03);
        wr(CONVERTER_STATUS_OFS, 8'h0F);
        // each detector input on its own flags the missing reference
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            ref_low_i <= (i == 0);
            ref_in_pos_open_i <= (i == 1);
            ref_in_neg_open_i <= (i == 2);
            repeat (6) @(posedge clk_i);
            rdchk("noref_set", CONVERTER_STATUS_OFS, 8'h10);
        end
        conv(1'b0, 16'h1234, 1'b0);
        rd16(1'b0, 16'hFFFF);
        conv(1'b1, 16'h0000, 1'b0);
        rd16(1'b1, 16'hFFFF);
        cal_base = cal_pulses;
        conv(1'b0, 16'h0100, 1'b1);
        conv(1'b1, 16'h0100, 1'b1);
        chk("cal_wr_blocked", 16'h0000, 16'(cal_pulses - cal_base));
        rdchk("cal_err", CONVERTER_STATUS_OFS, 8'h1F);
        rd16(1'b1, 16'hFFFF);
        @(posedge clk_i);
        ref_in_neg_open_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        rd(CONVERTER_STATUS_OFS, v);
        chk("noref_follow", 16'h000C, {8'h00, v & 8'h1C});
        wr(CONVERTER_STATUS_OFS, 8'h0C);
        rd(CONVERTER_STATUS_OFS, v);
        chk("err_clear", 16'h0000, {8'h00, v & 8'h1C});
        results();
    end
endmodule : adc_front_end_ref_detect_ctrl_bench
`default_nettype wire
